// [core/mcu_reset_sequencer.sv]
// Reset source merge, stretch and initialisation sequencing for the core
// Function
// [RULE1] Four sources enter reset: pin, power-on, watchdog, low voltage
// [RULE2] Internal reset stretches pin low by a delay
// [RULE3] Reset held while external pin stays low
// [RULE4] Pin reset in run/wait halts, safes I/O, restarts oscillator
// [RULE5] After pin release, wait delay, then initialise
// [RULE6] Pin reset in stop starts oscillator, safes I/O
// [RULE7] Power-on keeps reset, pulled-up inputs, no execution
// [RULE8] Power-on: delay starts when oscillator runs, then initialise
// [RULE9] Watchdog end-of-count resets and reloads watchdog counter
// [RULE10] Watchdog reset restarts like pin reset with delay
// [RULE11] Low voltage holds static reset until supply recovers
// [RULE12] Internal source active drives reset pin low
// [RULE13] Every reset clears stack, loads PC from vector
// [RULE14] After reset set interrupt flag, non-maskable mode
// [RULE15] Return from interrupt leaves non-maskable mode, enables interrupts
// [RULE16] At return, service pending interrupt else continue
// [RULE17] Every reset loads watchdog register reset value
// [RULE18] Delay counter restarts while any source is asserted
// [RULE19] Pin synchronised; I/O safed asynchronously
`timescale 1ns/1ps
`include "reset_seq_params.svh"

module mcu_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int STAB_CYCLES = `STAB_DELAY_CYCLES,
    parameter int OSC_CYCLES  = `OSC_START_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       resetPinIn,
    output logic            resetPinOut,
    output logic            resetPinOe,
    input  wire logic       powerOnDetect,
    input  wire logic       watchdogEndOfCount,
    input  wire logic       lowVoltageDetect,
    input  wire logic       stopMode,
    input  wire logic       oscRunning,
    input  wire logic       returnFromInterrupt,
    input  wire logic       interruptPending,
    output core_ctrl_t      coreCtrl,
    output logic            coreRun,
    output logic            interruptFlag,
    output logic            interruptsEnabled,
    output logic            serviceInterrupt,
    output logic            oscEnable
);

    localparam int CNT_W = $clog2(STAB_CYCLES + 1);

    // Pin samples through two flops; the second is the only reader of the first
    logic       pinMeta_q;
    logic       pinSync_q;
    logic       internalReq_q;
    logic       wasStopped_q;
    logic [CNT_W-1:0] delayCnt_q;
    logic [CNT_W-1:0] delayCnt_d;
    seq_state_t state_q;
    seq_state_t state_d;
    logic       intFlag_q;
    logic       intEn_q;
    logic       service_q;
    logic       initPulse_q;

    function automatic logic anyAsserted(input reset_src_t s);
        anyAsserted = s.pinLow | s.powerOn | s.watchdog | s.lowVoltage;
    endfunction : anyAsserted

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
        end else begin
            pinMeta_q <= resetPinIn;
            pinSync_q <= pinMeta_q; // RULE19
        end
    end

    // Internal sources are registered so the pin drive cannot loop back combinationally
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internalReq_q <= 1'b1;
        end else begin
            internalReq_q <= powerOnDetect | watchdogEndOfCount | lowVoltageDetect;
        end
    end

    reset_src_t sources;
    assign sources.pinLow     = ~pinSync_q; // RULE1
    assign sources.powerOn    = powerOnDetect; // RULE7
    assign sources.watchdog   = watchdogEndOfCount; // RULE9
    assign sources.lowVoltage = lowVoltageDetect; // RULE11

    wire anySource = anyAsserted(sources); // RULE1

    // Open drain: only pulls low, the board pull-up gives the high level
    assign resetPinOut = 1'b0;
    assign resetPinOe  = internalReq_q; // RULE12

    wire oscDone   = oscRunning;
    wire delayDone = (delayCnt_q == CNT_W'(STAB_CYCLES - 1));

    always_comb begin
        state_d    = state_q;
        delayCnt_d = delayCnt_q;
        if (anySource) begin
            state_d    = ST_RESET; // RULE3
            delayCnt_d = '0; // RULE18
        end else begin
            case (state_q)
                ST_RESET: begin
                    state_d = ST_OSC;
                end
                ST_OSC: begin
                    if (oscDone) begin
                        state_d = ST_STAB; // RULE8
                    end
                end
                ST_STAB: begin
                    if (delayDone) begin
                        state_d = ST_INIT; // RULE5 RULE10
                    end else begin
                        delayCnt_d = delayCnt_q + CNT_W'(1); // RULE2
                    end
                end
                ST_INIT: begin
                    state_d = ST_NMI; // RULE14
                end
                ST_NMI: begin
                    if (returnFromInterrupt) begin
                        state_d = ST_NORMAL; // RULE15
                    end
                end
                ST_NORMAL: begin
                    state_d = ST_NORMAL;
                end
                default: begin
                    state_d = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_RESET;
            delayCnt_q <= '0;
        end else begin
            state_q    <= state_d;
            delayCnt_q <= delayCnt_d;
        end
    end

    // Remember whether reset came out of stop so the oscillator start is reported
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wasStopped_q <= 1'b0;
        end else if (anySource && state_q != ST_RESET) begin
            wasStopped_q <= stopMode; // RULE6
        end else if (state_q == ST_INIT) begin
            wasStopped_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intFlag_q   <= 1'b1;
            intEn_q     <= 1'b0;
            service_q   <= 1'b0;
            initPulse_q <= 1'b0;
        end else begin
            initPulse_q <= (state_d == ST_INIT) && (state_q != ST_INIT);
            service_q   <= 1'b0;
            if (state_d == ST_RESET || state_d == ST_INIT) begin
                intFlag_q <= 1'b1; // RULE14
                intEn_q   <= 1'b0;
            end else if (state_q == ST_NMI && returnFromInterrupt) begin
                intFlag_q <= 1'b0; // RULE15
                intEn_q   <= 1'b1;
                service_q <= interruptPending; // RULE16
            end
        end
    end

    wire inReset = (state_q != ST_NMI) && (state_q != ST_NORMAL) && (state_q != ST_INIT);

    // Reset asserted by the pin reaches the I/O without waiting for a clock edge
    assign coreCtrl.ioSafe     = inReset | ~resetPinIn | ~rst_n; // RULE4 RULE19
    assign coreCtrl.coreHalt   = inReset; // RULE4 RULE7
    assign coreCtrl.oscRestart = (state_q == ST_RESET) | wasStopped_q; // RULE4 RULE6
    assign coreCtrl.stackClear = inReset; // RULE13
    assign coreCtrl.pcLoad     = initPulse_q; // RULE13
    assign coreCtrl.pcVector   = `RST_VECTOR_ADDR; // RULE13
    assign coreCtrl.wdogLoad   = inReset; // RULE9 RULE17
    assign coreCtrl.wdogValue  = `WDOG_RESET_VALUE; // RULE17

    assign oscEnable         = 1'b1;
    assign coreRun           = ~inReset;
    assign interruptFlag     = intFlag_q;
    assign interruptsEnabled = intEn_q;
    assign serviceInterrupt  = service_q;

endmodule : mcu_reset_sequencer

// [core/reset_seq_params.svh]
// Constants of the reset sequencer: vectors, reset values and timing counts
`ifndef RESET_SEQ_PARAMS_SVH
`define RESET_SEQ_PARAMS_SVH
`define RST_VECTOR_ADDR      12'hFFE
`define WDOG_RESET_VALUE     8'hFE
`define WDOG_CTRL_BIT        0
`define WDOG_SR_BIT          1
`define STAB_DELAY_CYCLES    4096
`define OSC_START_CYCLES     16
`define STACK_DEPTH          6
`endif

// [core/reset_seq_pkg.sv]
// Types shared by the reset sequencer
package reset_seq_pkg;
    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_OSC    = 3'b001,
        ST_STAB   = 3'b011,
        ST_INIT   = 3'b010,
        ST_NMI    = 3'b110,
        ST_NORMAL = 3'b111
    } seq_state_t;

    typedef struct packed {
        logic pinLow;
        logic powerOn;
        logic watchdog;
        logic lowVoltage;
    } reset_src_t;

    typedef struct packed {
        logic        coreHalt;
        logic        ioSafe;
        logic        oscRestart;
        logic        stackClear;
        logic        pcLoad;
        logic [11:0] pcVector;
        logic        wdogLoad;
        logic [7:0]  wdogValue;
    } core_ctrl_t;
endpackage : reset_seq_pkg

// [verification/board_reset_circuit.sv]
// Board side of the reset pin: pull-up, push switch and the device's open drain
`timescale 1ns/1ps
module board_reset_circuit (
    input  wire logic pressLow,
    input  wire logic devOe,
    input  wire logic devOut,
    output logic      pinLevel
);
    // Wired-AND: the pull-up wins only while nobody pulls low
    assign pinLevel = !(pressLow || (devOe && !devOut));
endmodule : board_reset_circuit

// [verification/mcu_reset_sequencer_props.sv]
// Port-level checks of the reset sequencer
`timescale 1ns/1ps
module mcu_reset_sequencer_props
    import reset_seq_pkg::*;
#(parameter int STAB_CYCLES = 8) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       resetPinIn,
    input wire logic       resetPinOe,
    input wire logic       powerOnDetect,
    input wire logic       watchdogEndOfCount,
    input wire logic       lowVoltageDetect,
    input wire logic       returnFromInterrupt,
    input wire logic       interruptPending,
    input wire core_ctrl_t coreCtrl,
    input wire logic       coreRun,
    input wire logic       interruptFlag,
    input wire logic       interruptsEnabled,
    input wire logic       serviceInterrupt
);
    logic [15:0] quietCnt_q;
    wire intSrc = powerOnDetect | watchdogEndOfCount | lowVoltageDetect;
    wire anySrc = intSrc | !resetPinIn;
    // Raw inputs, so this is an upper bound on the design's own delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) quietCnt_q <= 16'h0000;
        else if (anySrc) quietCnt_q <= 16'h0000;
        else if (!(&quietCnt_q)) quietCnt_q <= quietCnt_q + 16'h0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_oe; intSrc |=> resetPinOe; endproperty
    a_oe: assert property (p_oe) else $error("pin not pulled");
    property p_halt; intSrc |=> coreCtrl.coreHalt && !coreRun; endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_pin; !resetPinIn [*5] |-> coreCtrl.coreHalt; endproperty
    a_pin: assert property (p_pin) else $error("pin not held");
    property p_io; !resetPinIn |-> coreCtrl.ioSafe; endproperty
    a_io: assert property (p_io) else $error("io not safe");
    property p_vec; coreCtrl.pcLoad |-> coreCtrl.pcVector == 12'hFFE
        && coreCtrl.wdogValue == 8'hFE; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_nmi; $rose(coreRun) |-> interruptFlag && !interruptsEnabled; endproperty
    a_nmi: assert property (p_nmi) else $error("not nmi");
    property p_rfi; coreRun && $past(coreRun) && interruptFlag && returnFromInterrupt
        && !anySrc |=> !interruptFlag && interruptsEnabled
        && serviceInterrupt == $past(interruptPending); endproperty
    a_rfi: assert property (p_rfi) else $error("bad return");
    property p_refuse; !coreRun && returnFromInterrupt |=> !serviceInterrupt; endproperty
    a_refuse: assert property (p_refuse) else $error("return taken");
    property p_stab; $rose(coreRun) |-> quietCnt_q >= STAB_CYCLES; endproperty
    a_stab: assert property (p_stab) else $error("early run");
endmodule : mcu_reset_sequencer_props
bind mcu_reset_sequencer mcu_reset_sequencer_props #(.STAB_CYCLES(STAB_CYCLES)) props (.*);

// [verification/mcu_reset_sequencer_test.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module mcu_reset_sequencer_test;
    import reset_seq_pkg::*;
    localparam int STAB = 8;
    logic clk = 1'b0, rst_n = 1'b0, pressLow = 1'b0, stopMode = 1'b0, oscRunning = 1'b1;
    logic powerOnDetect = 1'b0, watchdogEndOfCount = 1'b0, lowVoltageDetect = 1'b0;
    logic returnFromInterrupt = 1'b0, interruptPending = 1'b0, serviceInterrupt;
    logic resetPinIn, resetPinOut, resetPinOe, coreRun, interruptFlag, interruptsEnabled;
    logic oscEnable;
    core_ctrl_t coreCtrl;
    int error_cnt = 0, total_checks = 0;
    initial forever #50 clk = !clk;
    board_reset_circuit board (.pressLow(pressLow), .devOe(resetPinOe),
        .devOut(resetPinOut), .pinLevel(resetPinIn));
    mcu_reset_sequencer #(.STAB_CYCLES(STAB)) uut (.*);
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report;
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic run_init(input logic pend);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (!(coreRun === 1'b1 && seen) && n < 300) begin
            @(negedge clk);
            n++;
            if (coreCtrl.pcLoad === 1'b1) begin
                seen = 1'b1;
                chk("vector", 12'hFFE, coreCtrl.pcVector);
                chk("wdogValue", 12'h0FE, coreCtrl.wdogValue);
            end
        end
        chk("pcLoad", 12'h001, seen);
        chk("delay", 12'h001, n > STAB);
        chk("nmiFlag", 12'h001, interruptFlag);
        chk("intEnabled", 12'h000, interruptsEnabled);
        @(posedge clk) interruptPending <= pend;
        @(posedge clk) returnFromInterrupt <= 1'b1;
        @(posedge clk) returnFromInterrupt <= 1'b0;
        @(negedge clk);
        chk("service", pend, serviceInterrupt);
        chk("nmiFlag", 12'h000, interruptFlag);
        chk("intEnabled", 12'h001, interruptsEnabled);
    endtask : run_init
    // Return pulses while the pin is low must be ignored
    task automatic t_pin(input logic stp, input int len);
        @(posedge clk) stopMode <= stp;
        @(posedge clk) pressLow <= 1'b1;
        repeat (len) @(posedge clk) returnFromInterrupt <= !returnFromInterrupt;
        @(negedge clk);
        chk("ioSafe", 12'h001, coreCtrl.ioSafe);
        @(posedge clk) pressLow <= 1'b0;
        repeat (3) @(negedge clk);
        chk("halt", 12'h001, coreCtrl.coreHalt);
        chk("run", 12'h000, coreRun);
        chk("stackClear", 12'h001, coreCtrl.stackClear);
        chk("wdogLoad", 12'h001, coreCtrl.wdogLoad);
        chk("oscRestart", 12'h001, coreCtrl.oscRestart);
        chk("service", 12'h000, serviceInterrupt);
        @(posedge clk) stopMode <= 1'b0;
        run_init(1'b0);
    endtask : t_pin
    task automatic t_src(input logic [2:0] sel);
        @(posedge clk) begin
            {powerOnDetect, watchdogEndOfCount, lowVoltageDetect} <= sel;
            oscRunning <= 1'b0;
        end
        repeat (3) @(negedge clk);
        chk("pinOe", 12'h001, resetPinOe);
        chk("pinLevel", 12'h000, resetPinIn);
        chk("pinOut", 12'h000, resetPinOut);
        chk("oscEnable", 12'h001, oscEnable);
        chk("wdogLoad", 12'h001, coreCtrl.wdogLoad);
        chk("halt", 12'h001, coreCtrl.coreHalt);
        @(posedge clk) {powerOnDetect, watchdogEndOfCount, lowVoltageDetect} <= 3'h0;
        repeat (12) @(negedge clk);
        chk("halt", 12'h001, coreCtrl.coreHalt);
        @(posedge clk) oscRunning <= 1'b1;
        run_init(1'b1);
    endtask : t_src
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        run_init(1'b1);
        t_pin(1'b0, 20);
        t_pin(1'b1, 2);
        for (int i = 0; i < 3; i++) t_src(3'h4 >> i);
        final_report();
    end
    initial begin
        #200us;
        error_cnt++;
        final_report();
    end
endmodule : mcu_reset_sequencer_test
